// *** loop_clock_cfg.svh ***
/*
 * register offsets, field positions, reset values and timing counts
 * for the loop ratio and status control block.
 * assumes: included by the testbench and by every design file that needs a number.
 */
`ifndef LOOP_CLOCK_CFG_SVH
`define LOOP_CLOCK_CFG_SVH

// register byte addresses on the apb bus
`define MULT_CTRL_ADDR 12'h000
`define STAT_CTRL_ADDR 12'h004
`define IRQ_STATUS_ADDR 12'h008
`define IRQ_MASK_ADDR 12'h00C
`define PROT_CTRL_ADDR 12'h010

// loop_status_control field positions
`define CLOCK_DIVIDE_SELECT_HI 8
`define CLOCK_DIVIDE_SELECT_LO 7
`define FAIL_DIS_BIT 6
`define OSC_GATE_BIT 5
`define MCLK_CLR_BIT 4
`define MCLK_FLAG_BIT 3
`define PWR_DOWN_BIT 2
`define LOCK_DONE_BIT 0

// reset values and multiplier limit
`define MULT_RESET 4'h0
`define CLOCK_DIVIDE_SELECT_RESET 2'h0
`define MULT_MAX 4'hA

// timing
`define LOCK_TIME_NS 2000
`define CLK_PERIOD_NS 40
`define MISS_TIME_NS 800

`endif

// *** loop_clock_pkg.sv ***
/*
 * types shared by the loop ratio and status control block.
 * assumes: nothing beyond the cfg header.
 */
package loop_clock_pkg;
    // processor clock source selection
    typedef enum logic [1:0] {
        SRC_OSC,
        SRC_LOOP,
        SRC_BACKUP
    } clk_source_t;

    // lock sequencer states
    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_WAIT,
        LOCK_SWITCH
    } lock_state_t;
endpackage : loop_clock_pkg

// *** clock_gap_switch.sv ***
/*
 * holds a new source and divide ratio until a quiet boundary so the
 * processor clock enable never produces a shortened pulse.
 * assumes: single ref_clk domain; requests are levels.
 */
`timescale 1ns/1ns
`default_nettype none
`include "loop_clock_cfg.svh"
module clock_gap_switch
    import loop_clock_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [1:0] req_div,
    input var clk_source_t req_src,
    output var clk_source_t cur_src,
    output logic [1:0] cur_div,
    output logic clk_pulse
);
    logic [1:0] phase;
    logic [1:0] next_phase;
    clk_source_t next_src;
    logic [1:0] next_div;
    logic next_pulse;

    function automatic logic [1:0] last_phase(input logic [1:0] d);
        // divide code to terminal phase: /4,/4,/2,/1
        case (d)
            2'h2: last_phase = 2'h1;
            2'h3: last_phase = 2'h0;
            default: last_phase = 2'h3;
        endcase
    endfunction : last_phase

    // only swap settings at the end of a full output period
    always_comb begin
        next_phase = phase + 2'h1;
        next_src = cur_src;
        next_div = cur_div;
        next_pulse = 1'b0;
        if (phase >= last_phase(cur_div)) begin
            next_phase = 2'h0;
            next_pulse = 1'b1;
            next_src = req_src;
            next_div = req_div;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= 2'h0;
            cur_src <= SRC_OSC;
            cur_div <= `CLOCK_DIVIDE_SELECT_RESET;
            clk_pulse <= 1'b0;
        end else begin
            phase <= next_phase;
            cur_src <= next_src;
            cur_div <= next_div;
            clk_pulse <= next_pulse;
        end
    end

    // only the divide-by-one setting may pulse on two edges in a row
    property p_no_short;
        @(posedge ref_clk) disable iff (sys_rst)
        clk_pulse |=> !clk_pulse || $past(cur_div) == 2'h3;
    endproperty
    a_no_short: assert property (p_no_short) else $error("short clock period");
endmodule : clock_gap_switch
`default_nettype wire

// *** osc_miss_detect.sv ***
/*
 * detects a missing oscillator: counts ref cycles without an oscillator tick.
 * assumes: osc_tick is a synchronous one-cycle pulse; clear is a pulse.
 */
`timescale 1ns/1ns
`default_nettype none
`include "loop_clock_cfg.svh"
module osc_miss_detect #(
    parameter int MISS_CYCLES = (`MISS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic hard_rst,
    input wire logic osc_tick,
    input wire logic enable,
    input wire logic clear,
    output logic missing
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic next_missing;

    // count idle cycles, flag once the limit is reached
    always_comb begin
        next_count = count;
        next_missing = missing;
        if (clear) begin
            next_count = 8'h00;
            next_missing = 1'b0;
        end else if (!enable || osc_tick) begin
            next_count = 8'h00;
        end else if (count >= 8'(MISS_CYCLES - 1)) begin
            next_missing = 1'b1;
        end else begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            count <= 8'h00;
            missing <= 1'b0;
        end else begin
            count <= next_count;
            missing <= next_missing;
        end
    end

    property p_clear_wins;
        @(posedge ref_clk) disable iff (hard_rst)
        clear |=> !missing;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("flag survived clear");
endmodule : osc_miss_detect
`default_nettype wire

// *** loop_ratio_ctrl.sv ***
/*
 * loop ratio and status control: apb registers, lock sequencing,
 * source and divide selection, missing clock status and interrupt.
 * assumes: apb master per protocol; osc_tick synchronous pulse per oscillator edge;
 * loop_locked from the analog loop; resets synchronous to ref_clk.
 */
// Notes on behaviour
// - multiplier zero means bypass; reset value is zero
// - dividers 0/1 give osc times multiplier over 4; 11..15 reserved
// - divide select in bits 8:7, 15-9 reserved; 00 and 01 divide by 4
// - divide select 10 divides processor clock by two
// - divide by one only with loop bypassed or powered down
// - registers reset only by external pin or watchdog reset; here sys_rst resets them too
// - register writes need protected write enable, else ignored; here irq mask and protect register writes need none
// - fail detect disable bit 6, default 0; set blocks backup clock
// - oscillator gate bit 5 blocks clock to loop, oscillator runs
// - watchdog stalls on crystal when gated; software disables it first
// - missing clock clear control at bit 4
// - writing one clears detection; zero no effect; reads zero
// - missing flag bit 3 read only; cleared by clear or pin reset
// - after multiplier write lock done is 0, osc over 2 runs; here only a write while the sequencer idles drops it
// - power down bit 2 keeps loop off; only used in bypass
`timescale 1ns/1ns
`default_nettype none
`include "loop_clock_cfg.svh"
module loop_ratio_ctrl
    import loop_clock_pkg::*;
#(
    parameter int LOCK_CYCLES = `LOCK_TIME_NS / `CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic external_reset_pin,
    input wire logic watchdog_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_tick,
    input wire logic loop_locked,
    input wire logic crystal_source,
    output logic oscillator_gate,
    output logic loop_power_down,
    output logic [3:0] loop_mult,
    output logic [1:0] cpu_src,
    output logic [1:0] cpu_div,
    output logic processor_clock_in,
    output logic watchdog_clock_stall,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////
    // register state
    logic [3:0] mult;
    logic [1:0] clock_divide_select;
    logic fail_detect_disable;
    logic gate_bit;
    logic pwr_bit;
    logic lock_done_flag;
    logic protected_write_enable;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [3:0] next_mult;
    logic [1:0] next_clock_divide_select;
    logic next_fail_dis;
    logic next_gate;
    logic next_pwr;
    logic next_prot;
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic hard_rst;
    logic wr_access;
    logic rd_access;
    logic clr_pulse;
    logic mult_write;
    logic missing_clock_flag;
    logic miss_prev;
    lock_state_t lock_state;
    lock_state_t next_lock_state;
    logic [15:0] lock_count;
    logic [15:0] next_lock_count;
    logic next_lock_done;
    clk_source_t want_src;
    clk_source_t cur_src;
    logic [1:0] want_div;
    logic [1:0] sw_div;
    logic sw_pulse;
    logic next_irq;

    function automatic logic [15:0] stat_word(input logic [1:0] ds, input logic fd, input logic og,
                                               input logic mf, input logic pd, input logic ld);
        // reserved bits 15-9 and 1 read zero, clear bit 4 reads zero
        stat_word = 16'h0000;
        stat_word[`CLOCK_DIVIDE_SELECT_HI:`CLOCK_DIVIDE_SELECT_LO] = ds;
        stat_word[`FAIL_DIS_BIT] = fd;
        stat_word[`OSC_GATE_BIT] = og;
        stat_word[`MCLK_FLAG_BIT] = mf;
        stat_word[`PWR_DOWN_BIT] = pd;
        stat_word[`LOCK_DONE_BIT] = ld;
    endfunction : stat_word

    // the system, pin or watchdog reset each resets the registers
    assign hard_rst = sys_rst | external_reset_pin | watchdog_rst;
    assign wr_access = psel & penable & pwrite & !pready;
    assign rd_access = psel & penable & !pwrite & !pready;
    assign clr_pulse = wr_access && paddr == `STAT_CTRL_ADDR && protected_write_enable
                       && pstrb[0] && pwdata[`MCLK_CLR_BIT];
    assign mult_write = wr_access && paddr == `MULT_CTRL_ADDR && protected_write_enable && pstrb[0];

    ////////////////////////////////////////////////////////////////////
    // missing oscillator detection; gate bit blocks the ticks
    osc_miss_detect u_miss (
        .ref_clk(ref_clk),
        .hard_rst(hard_rst),
        .osc_tick(osc_tick & !gate_bit),
        .enable(!fail_detect_disable),
        .clear(clr_pulse),
        .missing(missing_clock_flag)
    );

    ////////////////////////////////////////////////////////////////////
    // apb register file; one wait state so reads and writes answer in 2 access cycles
    always_comb begin
        next_mult = mult;
        next_clock_divide_select = clock_divide_select;
        next_fail_dis = fail_detect_disable;
        next_gate = gate_bit;
        next_pwr = pwr_bit;
        next_prot = protected_write_enable;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_prdata = prdata;
        next_pready = psel & penable & !pready;
        next_pslverr = 1'b0;
        if (wr_access) begin
            unique case (paddr)
                `MULT_CTRL_ADDR: begin
                    if (protected_write_enable && pstrb[0] && pwdata[3:0] <= `MULT_MAX) begin
                        next_mult = pwdata[3:0];
                    end
                end
                `STAT_CTRL_ADDR: begin
                    if (protected_write_enable) begin
                        if (pstrb[1] && pstrb[0]) begin
                            next_clock_divide_select = pwdata[`CLOCK_DIVIDE_SELECT_HI:`CLOCK_DIVIDE_SELECT_LO];
                        end
                        if (pstrb[0]) begin
                            next_fail_dis = pwdata[`FAIL_DIS_BIT];
                            next_gate = pwdata[`OSC_GATE_BIT];
                            next_pwr = pwdata[`PWR_DOWN_BIT];
                        end
                    end
                end
                `IRQ_MASK_ADDR: if (pstrb[0]) next_irq_mask = pwdata[1:0];
                `PROT_CTRL_ADDR: if (pstrb[0]) next_prot = pwdata[0];
                `IRQ_STATUS_ADDR: ;
                default: next_pslverr = 1'b1;
            endcase
        end
        if (rd_access) begin
            unique case (paddr)
                `MULT_CTRL_ADDR: next_prdata = {28'h0000000, mult};
                `STAT_CTRL_ADDR: next_prdata = {16'h0000, stat_word(clock_divide_select, fail_detect_disable,
                                               gate_bit, missing_clock_flag, pwr_bit, lock_done_flag)};
                `IRQ_STATUS_ADDR: next_prdata = {30'h00000000, irq_status};
                `IRQ_MASK_ADDR: next_prdata = {30'h00000000, irq_mask};
                `PROT_CTRL_ADDR: next_prdata = {31'h00000000, protected_write_enable};
                default: begin
                    next_prdata = 32'h00000000;
                    next_pslverr = 1'b1;
                end
            endcase
            if (paddr == `IRQ_STATUS_ADDR) next_irq_status = 2'h0; // read clears
        end
        // events: bit0 lock achieved, bit1 missing clock; set wins over clear
        if (next_lock_done && !lock_done_flag) next_irq_status[0] = 1'b1;
        if (missing_clock_flag && !miss_prev) next_irq_status[1] = 1'b1;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            mult <= `MULT_RESET;
            clock_divide_select <= `CLOCK_DIVIDE_SELECT_RESET;
            fail_detect_disable <= 1'b0;
            gate_bit <= 1'b0;
            pwr_bit <= 1'b0;
            protected_write_enable <= 1'b0;
            irq_status <= 2'h0;
            irq_mask <= 2'h0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            miss_prev <= 1'b0;
            irq <= 1'b0;
        end else begin
            mult <= next_mult;
            clock_divide_select <= next_clock_divide_select;
            fail_detect_disable <= next_fail_dis;
            gate_bit <= next_gate;
            pwr_bit <= next_pwr;
            protected_write_enable <= next_prot;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            miss_prev <= missing_clock_flag;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lock sequencer: a multiplier write in LOCK_IDLE drops lock and runs osc/2
    always_comb begin
        next_lock_state = lock_state;
        next_lock_count = lock_count;
        next_lock_done = lock_done_flag;
        unique case (lock_state)
            LOCK_IDLE: begin
                if (mult_write) begin
                    next_lock_state = LOCK_WAIT;
                    next_lock_count = 16'h0000;
                    next_lock_done = 1'b0;
                end
            end
            LOCK_WAIT: begin
                if (lock_count < 16'(LOCK_CYCLES)) next_lock_count = lock_count + 16'h0001;
                else if (loop_locked || mult == `MULT_RESET) next_lock_state = LOCK_SWITCH;
            end
            LOCK_SWITCH: begin
                next_lock_state = LOCK_IDLE;
                next_lock_done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            lock_state <= LOCK_IDLE;
            lock_count <= 16'h0000;
            lock_done_flag <= 1'b1;
        end else begin
            lock_state <= next_lock_state;
            lock_count <= next_lock_count;
            lock_done_flag <= next_lock_done;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // requested source and divide for the processor clock
    always_comb begin
        want_src = (mult == `MULT_RESET) ? SRC_OSC : SRC_LOOP;
        want_div = clock_divide_select;
        if (clock_divide_select == 2'h3 && mult != `MULT_RESET && !pwr_bit) want_div = 2'h2;
        if (!lock_done_flag) begin
            want_src = SRC_OSC;
            want_div = 2'h2;
        end
        if (missing_clock_flag && !fail_detect_disable) want_src = SRC_BACKUP;
    end

    // boundary-aligned switch keeps every pulse full length
    clock_gap_switch u_switch (
        .ref_clk(ref_clk),
        .sys_rst(hard_rst),
        .req_div(want_div),
        .req_src(want_src),
        .cur_src(cur_src),
        .cur_div(sw_div),
        .clk_pulse(sw_pulse)
    );

    // outputs, each registered
    always_ff @(posedge ref_clk) begin
        if (hard_rst) begin
            oscillator_gate <= 1'b0;
            loop_power_down <= 1'b0;
            loop_mult <= 4'h0;
            cpu_src <= 2'h0;
            cpu_div <= 2'h0;
            processor_clock_in <= 1'b0;
            watchdog_clock_stall <= 1'b0;
        end else begin
            oscillator_gate <= gate_bit;
            loop_power_down <= pwr_bit;
            loop_mult <= mult;
            cpu_src <= cur_src;
            cpu_div <= sw_div;
            processor_clock_in <= sw_pulse;
            watchdog_clock_stall <= gate_bit & crystal_source;
        end
    end

    property p_write_guard;
        @(posedge ref_clk) disable iff (hard_rst)
        (wr_access && paddr == `MULT_CTRL_ADDR && !protected_write_enable) |=> $stable(mult);
    endproperty
    a_write_guard: assert property (p_write_guard) else $error("unprotected write took effect");
    property p_lock_drop;
        @(posedge ref_clk) disable iff (hard_rst)
        mult_write && lock_state == LOCK_IDLE |=> !lock_done_flag ##1 want_div == 2'h2;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock flag kept after write");
    property p_no_div1_mult;
        @(posedge ref_clk) disable iff (hard_rst)
        (mult != `MULT_RESET && !pwr_bit) |-> want_div != 2'h3;
    endproperty
    a_no_div1_mult: assert property (p_no_div1_mult) else $error("divide by one with loop");
    property p_bypass;
        @(posedge ref_clk) disable iff (hard_rst)
        (mult == `MULT_RESET && !missing_clock_flag) |-> want_src == SRC_OSC;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not honoured");
    property p_no_backup;
        @(posedge ref_clk) disable iff (hard_rst)
        fail_detect_disable |-> want_src != SRC_BACKUP;
    endproperty
    a_no_backup: assert property (p_no_backup) else $error("backup with detect off");
    property p_clear_read;
        @(posedge ref_clk) disable iff (hard_rst)
        (pready && $past(rd_access) && $past(paddr) == `STAT_CTRL_ADDR) |-> !prdata[`MCLK_CLR_BIT];
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("clear bit read as one");
    property p_gate_out;
        @(posedge ref_clk) disable iff (hard_rst)
        gate_bit |=> oscillator_gate;
    endproperty
    a_gate_out: assert property (p_gate_out) else $error("gate not driven");
    property p_div_map;
        @(posedge ref_clk) disable iff (hard_rst)
        (lock_done_flag && clock_divide_select == 2'h2) |-> want_div == 2'h2;
    endproperty
    a_div_map: assert property (p_div_map) else $error("divide two not applied");
endmodule : loop_ratio_ctrl
`default_nettype wire

// *** osc_source_model.sv ***
/*
 * oscillator and loop model on the far side of the loop ratio block.
 * assumes: one ref_clk domain; osc_tick is a synchronous pulse train.
 */
`timescale 1ns/1ns
`default_nettype none
module osc_source_model #(
    parameter int LOCK_DLY = 6
) (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic [3:0] loop_mult,
    input wire logic loop_power_down,
    output logic osc_tick,
    output logic loop_locked
);
    logic [3:0] last_mult;
    int cnt;
    initial begin
        osc_tick = 1'b0;
        loop_locked = 1'b0;
        last_mult = 4'h0;
        cnt = 0;
    end
    // tick every second cycle; a stopped oscillator holds the line low
    // the loop relocks only after a quiet ratio, so lock never comes early
    always @(posedge ref_clk) begin
        last_mult <= loop_mult;
        osc_tick <= run & ~osc_tick;
        if (loop_mult != last_mult || loop_power_down || !run) begin
            cnt <= 0;
        end else if (cnt < LOCK_DLY) begin
            cnt <= cnt + 1;
        end
        loop_locked <= (cnt == LOCK_DLY);
    end
endmodule : osc_source_model
`default_nettype wire

// *** tb.sv ***
/*
 * self-checking bench for the loop ratio control block over apb.
 * assumes: design files and cfg header compiled first; 25 MHz ref clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "loop_clock_cfg.svh"
module tb;
    import loop_clock_pkg::*;
    logic ref_clk = 0, sys_rst = 1, external_reset_pin = 0, watchdog_rst = 0;
    logic psel = 0, penable = 0, pwrite = 0, run = 1, crystal_source = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, errv, osc_tick, loop_locked, oscillator_gate, loop_power_down;
    logic processor_clock_in, watchdog_clock_stall, irq;
    logic [3:0] loop_mult, m;
    logic [1:0] cpu_src, cpu_div;
    int failures = 0, samples_checked = 0;
    always #20 ref_clk = ~ref_clk;
    loop_ratio_ctrl #(.LOCK_CYCLES(4)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .external_reset_pin(external_reset_pin), .watchdog_rst(watchdog_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
        .loop_locked(loop_locked), .crystal_source(crystal_source), .oscillator_gate(oscillator_gate),
        .loop_power_down(loop_power_down), .loop_mult(loop_mult), .cpu_src(cpu_src), .cpu_div(cpu_div),
        .processor_clock_in(processor_clock_in), .watchdog_clock_stall(watchdog_clock_stall), .irq(irq));
    osc_source_model u_osc (.ref_clk(ref_clk), .run(run), .loop_mult(loop_mult),
        .loop_power_down(loop_power_down), .osc_tick(osc_tick), .loop_locked(loop_locked));
    ////////////////////////////////////////////////////////////////////////////////
    // one apb transfer; request held until pready is seen at a falling edge, then through the next rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // look mid-cycle so the registered answer is settled, then pass the edge that samples it
        do begin
            @(negedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rdv = prdata;
        errv = pslverr;
        @(posedge ref_clk);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk
    // expected status word from divide select and lock done
    function automatic logic [31:0] stat(input logic [1:0] d, input logic lk);
        return {23'h0, d, 6'h0, lk};
    endfunction : stat
    task automatic wait_lock();
        int n;
        n = 0;
        do begin
            apb(0, `STAT_CTRL_ADDR, 0);
            n++;
        end while (rdv[`LOCK_DONE_BIT] !== 1'b1 && n < 40);
        if (n >= 40) failures++;
    endtask : wait_lock
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #(6000 * 40);
        failures++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hA3237018));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        apb(0, `MULT_CTRL_ADDR, 0); chk(rdv, 32'h0);
        apb(0, `STAT_CTRL_ADDR, 0); chk(rdv, stat(2'h0, 1));
        apb(1, `MULT_CTRL_ADDR, 32'h5); apb(0, `MULT_CTRL_ADDR, 0); chk(rdv, 32'h0);
        apb(0, 12'h0F0, 0); chk({31'h0, errv}, 32'h1);
        $display("test reset and protection done");
        apb(1, `PROT_CTRL_ADDR, 32'h1);
        // every divide code while bypassed; /1 is legal here
        for (int d = 0; d < 4; d++) begin
            apb(1, `STAT_CTRL_ADDR, stat(d[1:0], 0));
            repeat (12) @(posedge ref_clk);
            chk({30'h0, cpu_div}, d);
            apb(0, `STAT_CTRL_ADDR, 0); chk(rdv, stat(d[1:0], 1));
        end
        apb(1, `STAT_CTRL_ADDR, 32'h0);
        m = 4'($urandom_range(1, 10));
        apb(1, `MULT_CTRL_ADDR, {28'h0, m});
        apb(0, `STAT_CTRL_ADDR, 0); chk(rdv, stat(2'h0, 0));
        wait_lock();
        apb(1, `MULT_CTRL_ADDR, 32'hB); apb(0, `MULT_CTRL_ADDR, 0); chk(rdv, {28'h0, m});
        apb(1, `STAT_CTRL_ADDR, stat(2'h3, 0));
        repeat (12) @(posedge ref_clk);
        chk({30'h0, cpu_div}, 32'h2);
        $display("test divide and multiplier done");
        apb(1, `STAT_CTRL_ADDR, 32'h0);
        apb(1, `MULT_CTRL_ADDR, 32'h0);
        wait_lock();
        crystal_source <= 1'b1;
        apb(1, `STAT_CTRL_ADDR, 32'h34);
        apb(0, `STAT_CTRL_ADDR, 0); chk(rdv, 32'h25);
        chk({30'h0, oscillator_gate, loop_power_down}, 32'h3);
        chk({31'h0, watchdog_clock_stall}, 32'h1);
        apb(1, `STAT_CTRL_ADDR, 32'h0);
        chk({31'h0, watchdog_clock_stall}, 32'h0);
        $display("test gate and power down done");
        run <= 1'b0;
        repeat (30) @(posedge ref_clk);
        apb(0, `STAT_CTRL_ADDR, 0); chk(rdv[`MCLK_FLAG_BIT], 1);
        chk({31'h0, irq}, 32'h0);
        apb(1, `IRQ_MASK_ADDR, 32'h2); chk({31'h0, irq}, 32'h1);
        run <= 1'b1;
        apb(1, `STAT_CTRL_ADDR, 32'h10); apb(0, `STAT_CTRL_ADDR, 0); chk(rdv[`MCLK_FLAG_BIT], 0);
        apb(0, `IRQ_STATUS_ADDR, 0); chk(rdv & 32'h2, 32'h2);
        @(posedge ref_clk); chk({31'h0, irq}, 32'h0);
        apb(1, `STAT_CTRL_ADDR, 32'h40);
        run <= 1'b0;
        repeat (30) @(posedge ref_clk);
        apb(0, `STAT_CTRL_ADDR, 0); chk(rdv[`MCLK_FLAG_BIT], 0);
        run <= 1'b1;
        $display("test missing clock done");
        external_reset_pin <= 1'b1; @(posedge ref_clk); external_reset_pin <= 1'b0; @(posedge ref_clk);
        apb(0, `STAT_CTRL_ADDR, 0); chk(rdv, stat(2'h0, 1));
        apb(1, `PROT_CTRL_ADDR, 32'h1); apb(1, `MULT_CTRL_ADDR, 32'h3);
        watchdog_rst <= 1'b1; @(posedge ref_clk); watchdog_rst <= 1'b0; @(posedge ref_clk);
        apb(0, `MULT_CTRL_ADDR, 0); chk(rdv, 32'h0);
        $display("test register resets done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
